// *** core/jmb_debug_port.sv ***
// Debug data-register port: memory data bus access, auto-increment
// access, single stage passthrough and the CPU control word.
// Assumes the TAP pins run on jtagTck and the CPU side on ref_clk.
//
// Function
// - Data-to-address drives data bus, returns old value
// - Data-to-address takes address from debug register
// - Data-at-PC loads data bus, PC gives address
// - Auto-increment: PC plus two per clock fall
// - Passthrough: TDO repeats TDI one TCK later
// - Passthrough releases CPU, data changes nothing
// - Sixteen bit control word as data register
// - Bit 0 drives read/write, 1 reads
// - Bit 3 requests controlled CPU halt
// - Bit 4 selects byte or word access
// - Bit 7 reads fetch state, read only
// - Bit 9 reads CPU synchronization
// - Bit 10 puts CPU under debug control
// - Bit 11 asserts CPU power-on reset
// - Bit 12 gives read/write and width to CPU
// - Bit 13 zero hands flash to debug
// - Bit 14 turns TDO around as input
// - Newer layout: bit 3 reads wait status
// - Instruction codes 85, 41, 43, FF hex
// - Update-IR, Capture-DR, Update-DR take effect
// - Instruction shifted least significant bit first
`include "jmb_defines.svh"
`default_nettype none

module jmb_debug_port
   import jmb_pkg::*;
#(
   parameter bit NEWER_LAYOUT = 1'b0
)
(
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   sys_rst,
   // Test access port
   input  wire logic                   jtagTck,
   input  wire logic                   jtagTms,
   input  wire logic                   jtagTdi,
   output wire logic                   jtagTdo,
   output wire logic                   jtagTdoEn,
   // CPU status
   input  wire logic                   cpuFetchState,
   input  wire logic                   cpuSynced,
   input  wire logic                   cpuWaiting,
   input  wire logic [`JMB_WORD_W-1:0] cpuDataIn,
   input  wire logic [`JMB_ADDR_W-1:0] cpuPc,
   input  wire logic                   cpuRwIn,
   input  wire logic                   cpuByteIn,
   input  wire logic [`JMB_ADDR_W-1:0] debugAddr,
   input  wire logic                   targetCpuClock,
   // CPU control
   output wire logic [`JMB_WORD_W-1:0] memDataBus,
   output wire logic                   memDataDrive,
   output wire logic [`JMB_ADDR_W-1:0] memAddrBus,
   output wire logic                   memAddrFromDebug,
   output wire logic                   cpuRead,
   output wire logic                   cpuByte,
   output wire logic                   cpuHaltReq,
   output wire logic                   cpuDebugOwn,
   output wire logic                   cpuPorReq,
   output wire logic                   flashToDebug,
   output wire logic                   pcAdvance,
   output wire logic [`JMB_ADDR_W-1:0] pcAdvanceValue
);

   // --------------------------------------------------------------
   // Parameter check
   // --------------------------------------------------------------
   if (NEWER_LAYOUT !== 1'b0 && NEWER_LAYOUT !== 1'b1)
   begin : g_bad_layout
      $error("NEWER_LAYOUT must be 0 or 1");
   end

   // --------------------------------------------------------------
   // Link reset: async assert, release on jtagTck
   // --------------------------------------------------------------
   logic [1:0]  tckRstPipe;
   logic        tckRst;

   always_ff @(posedge jtagTck or posedge sys_rst)
   begin
      if (sys_rst)
         tckRstPipe <= `JMB_RST_ON;
      else
         tckRstPipe <= {tckRstPipe[0], 1'b0};
   end
   assign tckRst = tckRstPipe[1];

   // --------------------------------------------------------------
   // Link domain
   // --------------------------------------------------------------
   jmb_tck_st_t tck_reg;
   jmb_tck_st_t tck_next;
   logic [`JMB_WORD_W-1:0] readBack;
   logic        dataMode;
   logic        passLike;

   always_comb
   begin
      readBack = tck_reg.ctrlWord & `JMB_CW_WMASK;
      readBack[`JMB_CW_FETCH] = tck_reg.fetchS[1];
      readBack[`JMB_CW_SYNC]  = tck_reg.syncS[1];
      if (NEWER_LAYOUT)
         readBack[`JMB_CW_WAIT] = tck_reg.waitS[1];
      dataMode = (tck_reg.mode == MODE_DATA_ADDR)
              || (tck_reg.mode == MODE_DATA_PC)
              || (tck_reg.mode == MODE_DATA_AUTO);
      passLike = !dataMode && (tck_reg.mode != MODE_CTRL_WR)
              && (tck_reg.mode != MODE_CTRL_RD);
      tck_next = tck_reg;
      tck_next.fetchS = {tck_reg.fetchS[0], cpuFetchState};
      tck_next.syncS  = {tck_reg.syncS[0], cpuSynced};
      tck_next.waitS  = {tck_reg.waitS[0], cpuWaiting};
      tck_next.dataS0 = cpuDataIn;
      tck_next.dataS1 = tck_reg.dataS0;
      case (tck_reg.tap)
         TAP_RESET:
         begin
            tck_next.tap = jtagTms ? TAP_RESET : TAP_IDLE;
            tck_next.mode = MODE_PASS;
            tck_next.released = 1'b1;
            if (!tck_reg.released || tck_reg.mode != MODE_PASS)
               tck_next.updToggle = !tck_reg.updToggle;
         end
         TAP_IDLE:   tck_next.tap = jtagTms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tck_next.tap = jtagTms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR:
         begin
            tck_next.tap = jtagTms ? TAP_EX1_DR : TAP_SH_DR;
            if (dataMode)
               tck_next.drShift = tck_reg.dataS1;
            else if (!passLike)
               tck_next.drShift = readBack;
            tck_next.bypassBit = 1'b0;
         end
         TAP_SH_DR:
         begin
            tck_next.tap = jtagTms ? TAP_EX1_DR : TAP_SH_DR;
            tck_next.drShift = {jtagTdi,
               tck_reg.drShift[`JMB_WORD_W-1:1]};
            tck_next.bypassBit = jtagTdi;
         end
         TAP_EX1_DR: tck_next.tap = jtagTms ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tck_next.tap = jtagTms ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tck_next.tap = jtagTms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR:
         begin
            tck_next.tap = jtagTms ? TAP_SEL_DR : TAP_IDLE;
            if (dataMode)
            begin
               tck_next.mdbWord = tck_reg.drShift;
               tck_next.updToggle = !tck_reg.updToggle;
            end
            else if (tck_reg.mode == MODE_CTRL_WR)
            begin
               tck_next.ctrlWord = tck_reg.drShift
                                 & `JMB_CW_WMASK;
               tck_next.released = 1'b0;
               tck_next.updToggle = !tck_reg.updToggle;
            end
         end
         TAP_SEL_IR: tck_next.tap = jtagTms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR:
         begin
            tck_next.tap = jtagTms ? TAP_EX1_IR : TAP_SH_IR;
            tck_next.irShift = `JMB_IR_CAPTURE;
         end
         TAP_SH_IR:
         begin
            tck_next.tap = jtagTms ? TAP_EX1_IR : TAP_SH_IR;
            tck_next.irShift = {jtagTdi,
               tck_reg.irShift[`JMB_IR_W-1:1]};
         end
         TAP_EX1_IR: tck_next.tap = jtagTms ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tck_next.tap = jtagTms ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tck_next.tap = jtagTms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR:
         begin
            tck_next.tap = jtagTms ? TAP_SEL_DR : TAP_IDLE;
            tck_next.updToggle = !tck_reg.updToggle;
            case (tck_reg.irShift)
               `JMB_IR_DATA_ADDR: tck_next.mode = MODE_DATA_ADDR;
               `JMB_IR_DATA_PC:   tck_next.mode = MODE_DATA_PC;
               `JMB_IR_DATA_AUTO: tck_next.mode = MODE_DATA_AUTO;
               `JMB_IR_CTRL_WR:   tck_next.mode = MODE_CTRL_WR;
               `JMB_IR_CTRL_RD:   tck_next.mode = MODE_CTRL_RD;
               `JMB_IR_RELEASE:   tck_next.mode = MODE_RELEASE;
               `JMB_IR_PASS:      tck_next.mode = MODE_PASS;
               default:           tck_next.mode = MODE_NONE;
            endcase
            if (tck_reg.irShift == `JMB_IR_PASS
             || tck_reg.irShift == `JMB_IR_RELEASE)
               tck_next.released = 1'b1;
         end
         default: tck_next.tap = TAP_RESET;
      endcase
   end

   always_ff @(posedge jtagTck or posedge tckRst)
   begin
      if (tckRst)
      begin
         tck_reg <= '0;
         tck_reg.tap <= TAP_RESET;
         tck_reg.mode <= MODE_PASS;
         tck_reg.released <= 1'b1;
         tck_reg.ctrlWord <= `JMB_CW_RESET;
      end
      else
         tck_reg <= tck_next;
   end

   assign jtagTdo = (tck_reg.tap == TAP_SH_IR) ? tck_reg.irShift[0]
                  : passLike ? tck_reg.bypassBit
                  : tck_reg.drShift[0];
   assign jtagTdoEn = (tck_reg.tap == TAP_SH_IR || tck_reg.tap == TAP_SH_DR)
                    && !tck_reg.ctrlWord[`JMB_CW_TURN];

   // --------------------------------------------------------------
   // CPU domain
   // --------------------------------------------------------------
   jmb_ref_st_t ref_reg;
   jmb_ref_st_t ref_next;
   logic        refActive;
   logic        cpuFall;

   always_comb
   begin
      refActive = !ref_reg.released;
      cpuFall = ref_reg.clkS[2] && !ref_reg.clkS[1];
      ref_next = ref_reg;
      ref_next.togS = {ref_reg.togS[1], ref_reg.togS[0],
                       tck_reg.updToggle};
      ref_next.clkS = {ref_reg.clkS[1], ref_reg.clkS[0],
                       targetCpuClock};
      if (ref_reg.togS[2] != ref_reg.togS[1])
      begin
         ref_next.mode = tck_reg.mode;
         ref_next.mdbWord = tck_reg.mdbWord;
         ref_next.ctrlWord = tck_reg.ctrlWord;
         ref_next.released = tck_reg.released;
      end
      ref_next.memDataBus = ref_reg.mdbWord;
      ref_next.memDataDrive = refActive
         && ((ref_reg.mode == MODE_DATA_ADDR)
          || (ref_reg.mode == MODE_DATA_PC)
          || (ref_reg.mode == MODE_DATA_AUTO));
      ref_next.memAddrFromDebug = refActive
         && (ref_reg.mode == MODE_DATA_ADDR);
      ref_next.memAddrBus = ref_next.memAddrFromDebug
         ? debugAddr : cpuPc;
      ref_next.cpuRead = ref_reg.ctrlWord[`JMB_CW_RELLB] ? cpuRwIn
         : ref_reg.ctrlWord[`JMB_CW_RW];
      ref_next.cpuByte = ref_reg.ctrlWord[`JMB_CW_RELLB] ? cpuByteIn
         : ref_reg.ctrlWord[`JMB_CW_BYTE];
      ref_next.cpuHaltReq = refActive && !NEWER_LAYOUT
         && ref_reg.ctrlWord[`JMB_CW_HALT];
      ref_next.cpuDebugOwn = refActive
         && ref_reg.ctrlWord[`JMB_CW_OWN];
      ref_next.cpuPorReq = refActive
         && ref_reg.ctrlWord[`JMB_CW_POR];
      ref_next.flashToDebug = refActive
         && !ref_reg.ctrlWord[`JMB_CW_FLASH];
      ref_next.pcAdvance = refActive && cpuFall
         && (ref_reg.mode == MODE_DATA_AUTO);
      ref_next.pcAdvanceValue = `JMB_ADDR_W'(cpuPc + `JMB_PC_STEP);
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ref_reg <= '0;
         ref_reg.mode <= MODE_PASS;
         ref_reg.released <= 1'b1;
         ref_reg.ctrlWord <= `JMB_CW_RESET;
      end
      else
         ref_reg <= ref_next;
   end

   assign memDataBus       = ref_reg.memDataBus;
   assign memDataDrive     = ref_reg.memDataDrive;
   assign memAddrBus       = ref_reg.memAddrBus;
   assign memAddrFromDebug = ref_reg.memAddrFromDebug;
   assign cpuRead          = ref_reg.cpuRead;
   assign cpuByte          = ref_reg.cpuByte;
   assign cpuHaltReq       = ref_reg.cpuHaltReq;
   assign cpuDebugOwn      = ref_reg.cpuDebugOwn;
   assign cpuPorReq        = ref_reg.cpuPorReq;
   assign flashToDebug     = ref_reg.flashToDebug;
   assign pcAdvance        = ref_reg.pcAdvance;
   assign pcAdvanceValue   = ref_reg.pcAdvanceValue;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   sequence s_cpu_fall;
      ref_reg.clkS[2] && !ref_reg.clkS[1]
      && ref_reg.mode == MODE_DATA_AUTO && !ref_reg.released;
   endsequence
   sequence s_step_pulse;
      pcAdvance && pcAdvanceValue == $past(cpuPc) + `JMB_PC_STEP
      ##1 !pcAdvance;
   endsequence
   property p_pc_step;
      @(posedge ref_clk) disable iff (sys_rst)
      s_cpu_fall |=> s_step_pulse;
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("pc step missing or wrong");
   property p_shift_lsb;
      @(posedge jtagTck) disable iff (tckRst)
      tck_reg.tap == TAP_SH_DR |=>
         tck_reg.drShift[`JMB_WORD_W-1] == $past(jtagTdi)
         && tck_reg.drShift[`JMB_WORD_W-2:0]
            == $past(tck_reg.drShift[`JMB_WORD_W-1:1]);
   endproperty
   a_shift_lsb: assert property (p_shift_lsb)
      else $error("data shift wrong");
   property p_pass_delay;
      @(posedge jtagTck) disable iff (tckRst)
      tck_reg.tap == TAP_SH_DR && tck_reg.mode == MODE_PASS
      ##1 tck_reg.tap == TAP_SH_DR |-> jtagTdo == $past(jtagTdi);
   endproperty
   a_pass_delay: assert property (p_pass_delay)
      else $error("passthrough delay wrong");
   property p_pass_release;
      @(posedge jtagTck) disable iff (tckRst)
      tck_reg.tap == TAP_UPD_IR && tck_reg.irShift == `JMB_IR_PASS
      |=> tck_reg.mode == MODE_PASS && tck_reg.released;
   endproperty
   a_pass_release: assert property (p_pass_release)
      else $error("passthrough did not release");
   property p_pass_inert;
      @(posedge jtagTck) disable iff (tckRst)
      tck_reg.tap == TAP_UPD_DR && tck_reg.mode == MODE_PASS
      |=> $stable(tck_reg.ctrlWord) && $stable(tck_reg.mdbWord);
   endproperty
   a_pass_inert: assert property (p_pass_inert)
      else $error("passthrough changed a register");
   property p_capture;
      @(posedge jtagTck) disable iff (tckRst)
      tck_reg.tap == TAP_CAP_DR && tck_reg.mode == MODE_CTRL_RD
      |=> tck_reg.drShift[`JMB_CW_FETCH] == $past(tck_reg.fetchS[1])
       && tck_reg.drShift[`JMB_CW_SYNC] == $past(tck_reg.syncS[1]);
   endproperty
   a_capture: assert property (p_capture)
      else $error("status capture wrong");
   property p_turn;
      @(posedge jtagTck) disable iff (tckRst)
      tck_reg.ctrlWord[`JMB_CW_TURN] |-> !jtagTdoEn;
   endproperty
   a_turn: assert property (p_turn)
      else $error("tdo driven while turned around");
   property p_addr_debug;
      @(posedge ref_clk) disable iff (sys_rst)
      ref_reg.mode == MODE_DATA_ADDR && !ref_reg.released
      |=> memAddrFromDebug && memAddrBus == $past(debugAddr);
   endproperty
   a_addr_debug: assert property (p_addr_debug)
      else $error("address not from debug register");
   property p_addr_pc;
      @(posedge ref_clk) disable iff (sys_rst)
      ref_reg.mode == MODE_DATA_PC
      |=> !memAddrFromDebug && memAddrBus == $past(cpuPc);
   endproperty
   a_addr_pc: assert property (p_addr_pc)
      else $error("address not from pc");
   property p_rw_word;
      @(posedge ref_clk) disable iff (sys_rst)
      !ref_reg.ctrlWord[`JMB_CW_RELLB]
      |=> cpuRead == $past(ref_reg.ctrlWord[`JMB_CW_RW])
       && cpuByte == $past(ref_reg.ctrlWord[`JMB_CW_BYTE]);
   endproperty
   a_rw_word: assert property (p_rw_word)
      else $error("read/write not from control word");
   property p_released;
      @(posedge ref_clk) disable iff (sys_rst)
      ref_reg.released |=> !cpuPorReq && !cpuDebugOwn
         && !memDataDrive;
   endproperty
   a_released: assert property (p_released)
      else $error("released cpu still driven");

endmodule // jmb_debug_port

`default_nettype wire

// *** shared/jmb_defines.svh ***
// Constants of the debug data-register block: instruction codes,
// control word bit positions, reset values and widths.
// Assumes inclusion by its bare name from package and design files.
`ifndef JMB_DEFINES_SVH
`define JMB_DEFINES_SVH

// -----------------------------------------------------------------
// Widths
// -----------------------------------------------------------------
`define JMB_IR_W         8
`define JMB_WORD_W       16
`define JMB_ADDR_W       16

// -----------------------------------------------------------------
// Instruction codes
// -----------------------------------------------------------------
`define JMB_IR_DATA_ADDR 8'h85
`define JMB_IR_DATA_PC   8'h41
`define JMB_IR_DATA_AUTO 8'h43
`define JMB_IR_PASS      8'hFF
`define JMB_IR_CTRL_WR   8'h13
`define JMB_IR_CTRL_RD   8'h14
`define JMB_IR_RELEASE   8'h15
`define JMB_IR_CAPTURE   8'h01

// -----------------------------------------------------------------
// Control word bits
// -----------------------------------------------------------------
`define JMB_CW_RW        0
`define JMB_CW_HALT      3
`define JMB_CW_WAIT      3
`define JMB_CW_BYTE      4
`define JMB_CW_FETCH     7
`define JMB_CW_SYNC      9
`define JMB_CW_OWN       10
`define JMB_CW_POR       11
`define JMB_CW_RELLB     12
`define JMB_CW_FLASH     13
`define JMB_CW_TURN      14
`define JMB_CW_WMASK     16'h7C19
`define JMB_CW_RESET     16'h2000

// -----------------------------------------------------------------
// Misc values
// -----------------------------------------------------------------
`define JMB_PC_STEP      16'h0002
`define JMB_RST_ON       2'h3
`define JMB_RST_OFF      2'h0

`endif

// *** shared/jmb_pkg.sv ***
// Types of the debug data-register block: TAP states, modes and
// the state records of both clock domains.
// Assumes jmb_defines.svh on the include path.
`include "jmb_defines.svh"
`default_nettype none

package jmb_pkg;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR,
      TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR,
      TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR,
      TAP_UPD_IR
   } jmb_tap_t;

   typedef enum logic [2:0] {
      MODE_NONE, MODE_DATA_ADDR, MODE_DATA_PC, MODE_DATA_AUTO,
      MODE_CTRL_WR, MODE_CTRL_RD, MODE_RELEASE, MODE_PASS
   } jmb_mode_t;

   typedef struct packed {
      jmb_tap_t                 tap;
      logic [`JMB_IR_W-1:0]     irShift;
      jmb_mode_t                mode;
      logic [`JMB_WORD_W-1:0]   drShift;
      logic                     bypassBit;
      logic [`JMB_WORD_W-1:0]   mdbWord;
      logic [`JMB_WORD_W-1:0]   ctrlWord;
      logic                     released;
      logic                     updToggle;
      logic [1:0]               fetchS;
      logic [1:0]               syncS;
      logic [1:0]               waitS;
      logic [`JMB_WORD_W-1:0]   dataS0;
      logic [`JMB_WORD_W-1:0]   dataS1;
   } jmb_tck_st_t;

   typedef struct packed {
      logic [2:0]               togS;
      logic [2:0]               clkS;
      jmb_mode_t                mode;
      logic [`JMB_WORD_W-1:0]   mdbWord;
      logic [`JMB_WORD_W-1:0]   ctrlWord;
      logic                     released;
      logic [`JMB_WORD_W-1:0]   memDataBus;
      logic                     memDataDrive;
      logic [`JMB_ADDR_W-1:0]   memAddrBus;
      logic                     memAddrFromDebug;
      logic                     cpuRead;
      logic                     cpuByte;
      logic                     cpuHaltReq;
      logic                     cpuDebugOwn;
      logic                     cpuPorReq;
      logic                     flashToDebug;
      logic                     pcAdvance;
      logic [`JMB_ADDR_W-1:0]   pcAdvanceValue;
   } jmb_ref_st_t;

endpackage : jmb_pkg

`default_nettype wire

// *** verification/jmb_prog_model.sv ***
// Programmer model: drives the TAP on a gated 6 ns TCK.
// Assumes the bench ties its pins to the debug port.
`default_nettype none
module jmb_prog_model (
   // Test access port
   output var logic jtagTck = 1'b0,
   output var logic jtagTms = 1'b1,
   output var logic jtagTdi = 1'b0,
   input  wire logic jtagTdo,
   input  wire logic jtagTdoEn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lastTdo = 1'b0;
   logic enAny = 1'b0;
   // One TCK period; TDO taken just before the rise
   task automatic tick(input logic ms, input logic di, output logic q);
      jtagTms = ms;
      jtagTdi = di;
      #2.5;
      q = jtagTdoEn ? jtagTdo : ~lastTdo;
      lastTdo = q;
      #0.5 jtagTck = 1'b1;
      #3 jtagTck = 1'b0;
   endtask
   task automatic idle(input logic ms, input int n);
      logic q;
      repeat (n) tick(ms, 1'b0, q);
   endtask
   // Idle, shift, Update, back to Idle, then spacing
   task automatic shift(input bit ir, input int n,
                        input logic [15:0] v, output logic [15:0] o);
      logic q;
      o = '0;
      enAny = 1'b0;
      tick(1'b1, 1'b0, q);
      if (ir)
         tick(1'b1, 1'b0, q);
      idle(1'b0, 2);
      for (int i = 0; i < n; i++)
      begin
         enAny = enAny | jtagTdoEn;
         tick(i == n - 1, v[i], q);
         o[i] = q;
      end
      tick(1'b1, 1'b0, q);
      idle(1'b0, 6);
   endtask
endmodule // jmb_prog_model
`default_nettype wire

// *** verification/tb_jtag_memory_bus_cpu_control.sv ***
// Bench: control word, data bus modes and passthrough.
// Assumes jmb_pkg, the defines header and the programmer model.
`include "jmb_defines.svh"
`default_nettype none
module tb_jtag_memory_bus_cpu_control;
   import jmb_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, sys_rst = 1, cpuFetchState = 0, cpuSynced = 0;
   logic cpuWaiting = 0, cpuRwIn = 0, cpuByteIn = 0, targetCpuClock = 1;
   logic [15:0] cpuDataIn = 0, cpuPc = 0, debugAddr = 0;
   wire logic jtagTck, jtagTms, jtagTdi, jtagTdo, jtagTdoEn;
   wire logic memDataDrive, memAddrFromDebug, cpuRead, cpuByte;
   wire logic cpuHaltReq, cpuDebugOwn, cpuPorReq, flashToDebug;
   wire logic pcAdvance;
   wire logic [15:0] memDataBus, memAddrBus, pcAdvanceValue;
   logic [15:0] w, lastW, o, d, v;
   logic [7:0] codes [3] = '{8'h85, 8'h41, 8'h43};
   int error_cnt = 0, checks = 0, cyc = 0, cnt;
   jmb_debug_port u_dut (.ref_clk, .sys_rst, .jtagTck, .jtagTms,
      .jtagTdi, .jtagTdo, .jtagTdoEn, .cpuFetchState, .cpuSynced,
      .cpuWaiting, .cpuDataIn, .cpuPc, .cpuRwIn, .cpuByteIn, .debugAddr,
      .targetCpuClock, .memDataBus, .memDataDrive, .memAddrBus,
      .memAddrFromDebug, .cpuRead, .cpuByte, .cpuHaltReq, .cpuDebugOwn,
      .cpuPorReq, .flashToDebug, .pcAdvance, .pcAdvanceValue);
   jmb_prog_model u_prog (.jtagTck, .jtagTms, .jtagTdi, .jtagTdo,
      .jtagTdoEn);
   always #5 ref_clk = ~ref_clk;
   function automatic logic [15:0] ctlExp(input logic [15:0] c);
      return {10'h000, ~c[13], c[11], c[10], c[3],
              c[12] ? cpuByteIn : c[4], c[12] ? cpuRwIn : c[0]};
   endfunction
   function automatic logic [15:0] relGot();
      return 16'({cpuDebugOwn, memDataDrive, flashToDebug});
   endfunction
   function automatic logic [15:0] ctlGot();
      return {10'h000, flashToDebug, cpuPorReq, cpuDebugOwn, cpuHaltReq,
              cpuByte, cpuRead};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic settle();
      repeat (10) @(negedge ref_clk);
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   initial
   begin
      void'($urandom(96));
      u_prog.idle(1'b1, 5);
      repeat (16) @(negedge ref_clk);
      sys_rst = 0;
      u_prog.idle(1'b1, 5);
      u_prog.idle(1'b0, 1);
      settle();
      chk("rst", 0, relGot());
      u_prog.shift(1, 8, `JMB_IR_CTRL_WR, o);
      chk("irCap", 16'h0001, o);
      lastW = `JMB_CW_RESET;
      for (int i = 0; i < 7; i++)
      begin
         @(negedge ref_clk);
         {cpuRwIn, cpuByteIn, cpuFetchState, cpuSynced, cpuWaiting}
            = 5'($urandom);
         w = 16'($urandom) & `JMB_CW_WMASK & 16'hBFFF;
         w = (i == 0) ? 16'h3C19 : (i == 4) ? 16'h4000 : w;
         w = (i == 6) ? 16'h0400 : w;
         v = lastW | {cpuSynced, 1'b0, cpuFetchState, 7'h00};
         u_prog.shift(0, 16, w, o);
         if (!lastW[14])
            chk("ctlRd", v, o);
         chk("tdoEn", !lastW[14], u_prog.enAny);
         settle();
         chk("ctlOut", ctlExp(w), ctlGot());
         lastW = w;
      end
      foreach (codes[k])
      begin
         @(negedge ref_clk);
         cpuDataIn = 16'($urandom);
         debugAddr = 16'($urandom);
         cpuPc = 16'($urandom) & 16'hFFFE;
         d = (k == 0) ? 16'hFFFF : 16'($urandom);
         // Auto access here targets plain memory only
         u_prog.shift(1, 8, 16'(codes[k]), o);
         u_prog.shift(0, 16, d, o);
         settle();
         chk("mdbOld", cpuDataIn, o);
         chk("mdb", d, memDataBus);
         chk("mdbDrv", 1, memDataDrive);
         chk("mab", k == 0 ? debugAddr : cpuPc, memAddrBus);
         chk("mabDbg", k == 0, memAddrFromDebug);
         cnt = 0;
         targetCpuClock = 0;
         repeat (8)
         begin
            @(posedge ref_clk);
            #1;
            if (pcAdvance === 1'b1)
            begin
               cnt++;
               v = pcAdvanceValue;
            end
         end
         @(negedge ref_clk);
         targetCpuClock = 1;
         chk("pcAdv", k == 2, 16'(cnt));
         if (k == 2)
            chk("pcVal", cpuPc + `JMB_PC_STEP, v);
      end
      u_prog.shift(1, 8, 16'(`JMB_IR_CTRL_RD), o);
      u_prog.shift(0, 16, 16'($urandom), o);
      v = lastW | {cpuSynced, 1'b0, cpuFetchState, 7'h00};
      chk("ctlCap", v, o);
      settle();
      chk("ctlKeep", ctlExp(lastW), ctlGot());
      u_prog.shift(1, 8, 16'(`JMB_IR_RELEASE), o);
      settle();
      chk("rel15", 0, relGot());
      u_prog.shift(1, 8, 16'(`JMB_IR_CTRL_WR), o);
      u_prog.shift(0, 16, lastW, o);
      settle();
      chk("ctlBack", ctlExp(lastW), ctlGot());
      u_prog.shift(1, 8, 16'(`JMB_IR_PASS), o);
      w = 16'($urandom);
      u_prog.shift(0, 16, w, o);
      chk("pass", {w[14:0], 1'b0}, o);
      u_prog.shift(1, 8, 16'h0000, o);
      u_prog.shift(0, 16, ~w, o);
      chk("none", {~w[14:0], 1'b0}, o);
      settle();
      chk("rel", 0, relGot());
      chk("mdbKeep", d, memDataBus);
      u_prog.shift(1, 8, 16'(`JMB_IR_CTRL_WR), o);
      u_prog.shift(0, 16, lastW, o);
      settle();
      chk("own", 16'h0001, 16'(cpuDebugOwn));
      u_prog.idle(1'b1, 5);
      u_prog.idle(1'b0, 1);
      settle();
      chk("tlr", 0, relGot());
      print_verdict();
   end
endmodule // tb_jtag_memory_bus_cpu_control
`default_nettype wire
